/* File: core/eqf_defs.vh */
// register offsets, field layout and reset values of the channel b equalizer filter coefficients
`ifndef EQF_DEFS_VH
`define EQF_DEFS_VH

`define EQF_ADDR_W          12
`define EQF_TAP6_OFFSET     12'h453
`define EQF_TAP7_OFFSET     12'h455
`define EQF_TAP8_OFFSET     12'h457
`define EQF_TAP9_OFFSET     12'h459
`define EQF_TAP1_OFFSET     12'h448
`define EQF_TAP2_OFFSET     12'h44a
`define EQF_TAP3_OFFSET     12'h44c
`define EQF_TAP4_OFFSET     12'h44e
`define EQF_TAP5_OFFSET     12'h450
`define EQF_MODE_OFFSET     12'h460
`define EQF_REG_W           16
`define EQF_COEFF_W         12
`define EQF_CTAP_W          18
`define EQF_COEFF_MSB       11
`define EQF_REG_RESET       16'h0000
`define EQF_NUM_TAPS        9

`endif

/* File: core/eqf_coeff_regs.v */
// channel b equalizer filter: tap six to nine coefficient registers and nine tap datapath
//
// What this block does
// R1 - each coefficient is 12-bit signed two's complement in bits 11:0 of 16-bit register
// R2 - registers at 0x455, 0x457, 0x459 feed taps seven, eight and nine
// R3 - tap-six register feeds sixth tap, just before the seventh tap
// R4 - these coefficients drive only the channel b filter, only in dual-channel mode
// R5 - reset clears every coefficient register to zero, reserved bits too
// R6 - reading the ninth-tap register always returns zero in the coefficient msb
// R7 - nine taps; fifth is centre tap with 18-bit coefficient, others 12-bit
// R8 - output is the sum of nine coefficient-sample products, tap one on newest sample
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "eqf_defs.vh"

module eqf_coeff_regs #(
    parameter SAMPLE_W = 12,
    parameter ACC_W    = 34
) (
    input  wire                        clk_i,
    input  wire                        reset_i,
    input  wire [`EQF_ADDR_W-1:0]      reg_addr_i,
    input  wire [`EQF_REG_W-1:0]       reg_wdata_i,
    input  wire                        reg_wr_i,
    input  wire                        reg_rd_i,
    output reg  [`EQF_REG_W-1:0]       reg_rdata_o,
    input  wire [`EQF_COEFF_W*4-1:0]   tap1_4_coeff_i,
    input  wire [`EQF_CTAP_W-1:0]      tap5_coeff_i,
    input  wire                        sample_valid_i,
    input  wire signed [SAMPLE_W-1:0]  sample_i,
    output reg                         out_valid_o,
    output reg  signed [ACC_W-1:0]     filter_out_o,
    output reg                         dual_mode_o
);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    // index 0..3 hold taps six to nine; whole 16-bit words kept, reserved bits are r/w
    reg  [`EQF_REG_W-1:0] coeff_r [0:3];
    reg                   dual_mode_r;

    function [2:0] tap_index;
        input [`EQF_ADDR_W-1:0] addr;
        begin
            case (addr)
                `EQF_TAP6_OFFSET: tap_index = 3'b100;
                `EQF_TAP7_OFFSET: tap_index = 3'b101;
                `EQF_TAP8_OFFSET: tap_index = 3'b110;
                `EQF_TAP9_OFFSET: tap_index = 3'b111;
                default:          tap_index = 3'b000;
            endcase
        end
    endfunction

    wire [2:0] wr_idx;
    wire [2:0] rd_idx;
    assign wr_idx = tap_index(reg_addr_i);
    assign rd_idx = tap_index(reg_addr_i);

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_coeff
            always @(posedge clk_i) begin
                if (reset_i) begin
                    coeff_r[g] <= `EQF_REG_RESET; // R5
                end else if (reg_wr_i && wr_idx[2] && (wr_idx[1:0] == g)) begin
                    coeff_r[g] <= reg_wdata_i; // R2 R3
                end
            end
        end
    endgenerate

    always @(posedge clk_i) begin
        if (reset_i) begin
            dual_mode_r <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == `EQF_MODE_OFFSET) begin
            dual_mode_r <= reg_wdata_i[0];
        end
    end

    // read data stands only in the cycle after the strobe; unmapped reads return zero
    reg [`EQF_REG_W-1:0] rdata_nxt;
    always @* begin
        rdata_nxt = {`EQF_REG_W{1'b0}};
        if (reg_rd_i) begin
            if (rd_idx[2]) begin
                rdata_nxt = coeff_r[rd_idx[1:0]];
                if (rd_idx[1:0] == 2'b11) begin
                    // readback path of the ninth tap loses its sign bit
                    rdata_nxt[`EQF_COEFF_MSB] = 1'b0; // R6
                end
            end else if (reg_addr_i == `EQF_MODE_OFFSET) begin
                rdata_nxt = {{(`EQF_REG_W-1){1'b0}}, dual_mode_r};
            end
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= {`EQF_REG_W{1'b0}};
            dual_mode_o <= 1'b0;
        end else begin
            reg_rdata_o <= rdata_nxt;
            dual_mode_o <= dual_mode_r;
        end
    end

    // ------------------------------------------------------------
    // filter datapath
    // ------------------------------------------------------------
    // coefficients in tap order one to nine, sign-extended to the centre tap width
    wire signed [`EQF_CTAP_W-1:0] tap_c [0:8];
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_low
            assign tap_c[g] = {{(`EQF_CTAP_W-`EQF_COEFF_W){tap1_4_coeff_i[g*12+11]}},
                               tap1_4_coeff_i[g*12 +: 12]}; // R1 R7
            assign tap_c[g+5] = {{(`EQF_CTAP_W-`EQF_COEFF_W){coeff_r[g][`EQF_COEFF_MSB]}},
                                 coeff_r[g][`EQF_COEFF_W-1:0]}; // R1 R3 R2
        end
    endgenerate
    assign tap_c[4] = tap5_coeff_i; // R7

    // delay line: stage 0 is the newest sample
    reg signed [SAMPLE_W-1:0] dly_r [0:8];
    integer k;
    always @(posedge clk_i) begin
        if (reset_i) begin
            for (k = 0; k < 9; k = k + 1) begin
                dly_r[k] <= {SAMPLE_W{1'b0}};
            end
        end else if (sample_valid_i && dual_mode_r) begin // R4
            dly_r[0] <= sample_i;
            for (k = 1; k < 9; k = k + 1) begin
                dly_r[k] <= dly_r[k-1];
            end
        end
    end

    // products of 18 x 12 bits need 30 bits; nine of them fit in ACC_W
    // own loop index so the delay line process stays the only driver of k
    reg signed [ACC_W-1:0] acc_nxt;
    integer j;
    always @* begin
        acc_nxt = {ACC_W{1'b0}};
        for (j = 0; j < 9; j = j + 1) begin
            acc_nxt = acc_nxt + tap_c[j] * dly_r[j]; // R8
        end
    end

    reg load_r;
    always @(posedge clk_i) begin
        if (reset_i) begin
            load_r       <= 1'b0;
            out_valid_o  <= 1'b0;
            filter_out_o <= {ACC_W{1'b0}};
        end else begin
            load_r      <= sample_valid_i && dual_mode_r;
            out_valid_o <= load_r;
            if (load_r) begin
                filter_out_o <= acc_nxt; // R8
            end
        end
    end

endmodule // eqf_coeff_regs
`default_nettype wire

/* File: dv/eqf_coeff_regs_assertions.sv */
// checker for the channel b coefficient registers and filter outputs
`timescale 1ns/1ns
`default_nettype none
module eqf_chk #(parameter ACC_W = 34) (
    input wire logic             clk_i,
    input wire logic             reset_i,
    input wire logic [11:0]      reg_addr_i,
    input wire logic [15:0]      reg_wdata_i,
    input wire logic             reg_wr_i,
    input wire logic             reg_rd_i,
    input wire logic [15:0]      reg_rdata_o,
    input wire logic             sample_valid_i,
    input wire logic             out_valid_o,
    input wire logic [ACC_W-1:0] filter_out_o,
    input wire logic             dual_mode_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (reset_i);
a_rd_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0)
    else $error("read data outside read slot");
a_tap9_msb: assert property ($past(reg_rd_i && reg_addr_i == 12'h459) |-> !reg_rdata_o[11])
    else $error("ninth tap msb read back set");
a_out_lat: assert property (sample_valid_i ##1 dual_mode_o |-> ##1 out_valid_o)
    else $error("filter output late");
a_out_cause: assert property (out_valid_o |-> $past(sample_valid_i, 2))
    else $error("output without sample");
a_out_hold: assert property (!out_valid_o |-> $stable(filter_out_o))
    else $error("output moved without valid");
a_unmapped_zero: assert property ($past(reg_rd_i && !(reg_addr_i inside
    {12'h453, 12'h455, 12'h457, 12'h459, 12'h460})) |-> reg_rdata_o == 16'h0)
    else $error("unmapped read not zero");
a_tap8_back: assert property (reg_wr_i && reg_addr_i == 12'h457 ##1
    reg_rd_i && reg_addr_i == 12'h457 |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("eighth tap readback wrong");
a_tap9_back: assert property (reg_wr_i && reg_addr_i == 12'h459 ##1
    reg_rd_i && reg_addr_i == 12'h459 |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 16'hf7ff))
    else $error("ninth tap readback wrong");
c_rd9: cover property (reg_rd_i && reg_addr_i == 12'h459);
c_out: cover property (out_valid_o);
c_mode: cover property ($rose(dual_mode_o));
endmodule // eqf_chk
bind eqf_coeff_regs eqf_chk #(.ACC_W(ACC_W)) u_chk (.*);
`default_nettype wire

/* File: dv/test_eqf_coeff_regs.sv */
// self-checking bench for the channel b coefficient registers and filter
`timescale 1ns/1ns
`default_nettype none
module test_eqf_coeff_regs;
logic clk_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0, sample_valid_i = 0, got;
logic [11:0] reg_addr_i = 0;
logic [15:0] reg_wdata_i = 0, reg_rdata_o;
logic [47:0] tap1_4_coeff_i = {12'h004, 12'h003, 12'h002, 12'h001};
logic [17:0] tap5_coeff_i = 18'h3fffb;
logic signed [11:0] sample_i = 0;
logic out_valid_o, dual_mode_o;
logic signed [33:0] filter_out_o;
int failures = 0, n_checks = 0, i, k;
logic signed [33:0] ex [9] = '{1, 2, 3, 4, -5, -2048, 2047, 291, -1348};
logic [11:0] ad [6] = '{12'h453, 12'h455, 12'h457, 12'h459, 12'h460, 12'h461};
logic [15:0] wv [4] = '{16'hf800, 16'h07ff, 16'h0123, 16'h0abc};
always #25 clk_i = ~clk_i;
eqf_coeff_regs dut (.*);
task chk(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e) begin
        failures++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
endtask
task wr(input logic [11:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1;
    @(posedge clk_i);
    reg_wr_i <= 0;
endtask
task rd(input logic [11:0] a, input logic [15:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1;
    @(posedge clk_i);
    reg_rd_i <= 0;
    #1 chk({18'h0, reg_rdata_o}, {18'h0, e});
endtask
// bounded wait: a missing output leaves got low and the caller counts it
task smp(input logic signed [11:0] v);
    sample_i <= v;
    sample_valid_i <= 1;
    @(posedge clk_i);
    sample_valid_i <= 0;
    got = 0;
    for (k = 0; k < 4 && !got; k++) begin
        @(posedge clk_i);
        #1 got = (out_valid_o === 1'b1);
    end
endtask
task end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 0;
    for (i = 0; i < 6; i++) rd(ad[i], 16'h0);
    smp(12'sd7);
    chk({33'h0, got}, 34'h0);
    for (i = 0; i < 4; i++) begin
        wr(ad[i], wv[i]);
        rd(ad[i], wv[i] & (i == 3 ? 16'hf7ff : 16'hffff));
    end
    wr(12'h461, 16'hffff);
    rd(12'h461, 16'h0);
    wr(12'h460, 16'h0001);
    rd(12'h460, 16'h0001);
    chk({33'h0, dual_mode_o}, 34'h1);
    for (i = 0; i < 9; i++) begin
        smp(i == 0 ? 12'sd1 : 12'sd0);
        chk({33'h0, got}, 34'h1);
        chk(filter_out_o, ex[i]);
    end
    reset_i <= 1;
    repeat (2) @(posedge clk_i);
    reset_i <= 0;
    rd(ad[3], 16'h0);
    rd(ad[4], 16'h0);
    chk({33'h0, dual_mode_o}, 34'h0);
    chk(filter_out_o, 34'h0);
    chk({33'h0, out_valid_o}, 34'h0);
    end_sim;
end
endmodule // test_eqf_coeff_regs
`default_nettype wire
